// ---- bec_pkg.sv ----
// Package: constants, register map and BCD helpers for the event counters
package bec_pkg;
   // Timing
   localparam int unsigned CLK_HZ   = 100_000_000;
   localparam int unsigned TICK_MS  = 100;               // Timer step of 0.1 s
   localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   // Register word indexes (byte address = index * 4)
   localparam logic [11:0] IDX_CTRL   = 12'h000;
   localparam logic [11:0] IDX_PSEL   = 12'h001;
   localparam logic [11:0] IDX_PUP    = 12'h002;
   localparam logic [11:0] IDX_PBD_LO = 12'h003;
   localparam logic [11:0] IDX_PBD_HI = 12'h004;
   localparam logic [11:0] IDX_PSG    = 12'h005;
   localparam logic [11:0] IDX_PTM_LO = 12'h006;
   localparam logic [11:0] IDX_PTM_HI = 12'h007;
   localparam logic [11:0] IDX_DONE   = 12'h008;
   localparam logic [11:0] IDX_STS    = 12'h009;
   localparam logic [11:0] IDX_MSK    = 12'h00A;
   localparam logic [11:0] IDX_TM_LO  = 12'h00B;
   localparam logic [11:0] IDX_TM_HI  = 12'h00C;
   // Variable store: slot n at octal 1000 + n
   localparam logic [11:0] IDX_CV_BASE = 12'h200;
   localparam logic [11:0] SLOT_UP     = 12'h000;
   localparam logic [11:0] SLOT_BD     = 12'h002;        // Also holds slot 3
   localparam logic [11:0] SLOT_SG     = 12'h004;
   localparam logic [11:0] IDX_CV_UP   = IDX_CV_BASE + SLOT_UP;
   localparam logic [11:0] IDX_CV_BDL  = IDX_CV_BASE + SLOT_BD;
   localparam logic [11:0] IDX_CV_BDH  = IDX_CV_BASE + SLOT_BD + 12'h001;
   localparam logic [11:0] IDX_CV_SG   = IDX_CV_BASE + SLOT_SG;
   // Field positions
   localparam int CTRL_SG_CLR = 0;
   localparam int DONE_UP = 0;
   localparam int DONE_BD = 1;
   localparam int DONE_SG = 2;
   localparam int DONE_TM = 3;
   // Reset values and constant operands
   localparam logic [3:0]  PSEL_RST = 4'h0;              // All use constants
   localparam logic [15:0] K_UP = 16'h0003;
   localparam logic [31:0] K_BD = 32'h0000_0003;
   localparam logic [15:0] K_SG = 16'h0003;
   localparam logic [31:0] K_TM = 32'h0000_0030;         // 3 s in tenths
   localparam logic [15:0] MAX4 = 16'h9999;
   localparam logic [31:0] MAX8 = 32'h9999_9999;

   // Decimal increment with digit carries
   function automatic logic [31:0] bcd_inc(input logic [31:0] v);
      logic [31:0] r;
      logic        c;
      r = v;
      c = 1'b1;
      for (int i = 0; i < 8; i++) begin
         if (c) begin
            if (r[i*4+:4] == 4'h9) begin
               r[i*4+:4] = 4'h0;
            end else begin
               r[i*4+:4] = r[i*4+:4] + 4'h1;
               c = 1'b0;
            end
         end
      end
      return r;
   endfunction : bcd_inc

   // Decimal decrement with digit borrows
   function automatic logic [31:0] bcd_dec(input logic [31:0] v);
      logic [31:0] r;
      logic        b;
      r = v;
      b = 1'b1;
      for (int i = 0; i < 8; i++) begin
         if (b) begin
            if (r[i*4+:4] == 4'h0) begin
               r[i*4+:4] = 4'h9;
            end else begin
               r[i*4+:4] = r[i*4+:4] - 4'h1;
               b = 1'b0;
            end
         end
      end
      return r;
   endfunction : bcd_dec

   // True when every nibble is a decimal digit
   function automatic logic bcd_ok(input logic [31:0] v);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 8; i++) begin
         if (v[i*4+:4] > 4'h9) ok = 1'b0;
      end
      return ok;
   endfunction : bcd_ok
endpackage : bec_pkg

// ---- bec_counters.sv ----
// Scan-clocked BCD event counters and accumulating timer with Wishbone access
// Function
// - Up counter adds one per rising count
// - Clear held on keeps up value zero
// - Up done tracks value at least preset
// - Four-digit counters saturate at 9999, no wrap
// - Up preset and value are 4-digit BCD
// - Slot value readable at octal 1000 plus n
// - Preset from constant or variable store
// - Bidirectional counter limited 0 to 99999999
// - Bidirectional preset and value 8-digit BCD
// - Bidirectional counter occupies two slots
// - Timer accumulates, done at 3 s, clearable
// - Stage counter counts rises, no clear input
// - Stage value held until clear command
// - Up/down count only with other input off
// - Timer enable off keeps elapsed time
`timescale 1ns/1ps
`default_nettype none
module bec_counters #(
   parameter int unsigned TICK_CYC = bec_pkg::TICK_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        scan_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [13:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output wire logic [31:0] wb_dat_o,
   output wire logic        wb_ack_o,
   input  wire logic        up_cnt_i,
   input  wire logic        up_clr_i,
   input  wire logic        bd_up_i,
   input  wire logic        bd_dn_i,
   input  wire logic        bd_clr_i,
   input  wire logic        sg_cnt_i,
   input  wire logic        tm_en_i,
   input  wire logic        tm_clr_i,
   output wire logic        up_done_o,
   output wire logic        bd_done_o,
   output wire logic        sg_done_o,
   output wire logic        tm_done_o,
   output wire logic        irq_o
);
   localparam logic [23:0] TICK_LAST = 24'(TICK_CYC - 1);

   logic [31:0] dat_q, rd_d, wm;
   logic        ack_q, irq_q, wr_en, sg_clr_w, tick;
   logic [11:0] idx;
   logic [3:0]  in_now, prev_q, rise, psel_q, msk_q, sts_q, done_q, done_d;
   logic [15:0] pup_q, psg_q, up_val_q, sg_val_q, pre_up, pre_sg;
   logic [31:0] pbd_q, ptm_q, bd_val_q, tm_val_q, pre_bd, pre_tm;
   logic [31:0] up_inc_w, bd_inc_w, bd_dec_w, sg_inc_w, tm_inc_w;
   logic [23:0] div_q;
   logic        up_ge;

   assign idx      = wb_adr_i[13:2];
   assign tick     = ce_i & scan_i;
   // Write lands on the edge where the master sees ack
   assign wr_en    = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
   assign sg_clr_w = wr_en & (idx == bec_pkg::IDX_CTRL)
                     & wb_sel_i[0] & wb_dat_i[bec_pkg::CTRL_SG_CLR];
   assign wm = {wb_sel_i[3] ? wb_dat_i[31:24] : rd_d[31:24],
                wb_sel_i[2] ? wb_dat_i[23:16] : rd_d[23:16],
                wb_sel_i[1] ? wb_dat_i[15:8]  : rd_d[15:8],
                wb_sel_i[0] ? wb_dat_i[7:0]   : rd_d[7:0]};

   // Preset source per counter: constant operand or store word
   assign pre_up = psel_q[0] ? pup_q : bec_pkg::K_UP;
   assign pre_bd = psel_q[1] ? pbd_q : bec_pkg::K_BD;
   assign pre_sg = psel_q[2] ? psg_q : bec_pkg::K_SG;
   assign pre_tm = psel_q[3] ? ptm_q : bec_pkg::K_TM;

   // Digit arithmetic for all counters
   assign up_inc_w = bec_pkg::bcd_inc({16'h0000, up_val_q});
   assign sg_inc_w = bec_pkg::bcd_inc({16'h0000, sg_val_q});
   assign bd_inc_w = bec_pkg::bcd_inc(bd_val_q);
   assign bd_dec_w = bec_pkg::bcd_dec(bd_val_q);
   assign tm_inc_w = bec_pkg::bcd_inc(tm_val_q);

   // Edge detect against the level held from the last scan
   assign in_now = {sg_cnt_i, bd_dn_i, bd_up_i, up_cnt_i};
   assign rise   = in_now & ~prev_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_q <= 4'h0;
      end else if (tick) begin
         prev_q <= in_now;
      end
   end

   // Up counter: clear dominates, saturates rather than wrapping
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         up_val_q <= 16'h0000;
      end else if (tick) begin
         if (up_clr_i) begin
            up_val_q <= 16'h0000;
         end else if (rise[0] && up_val_q != bec_pkg::MAX4) begin
            up_val_q <= up_inc_w[15:0];
         end
      end
   end

   // Up/down counter; both edges in one scan cancel out
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bd_val_q <= 32'h0000_0000;
      end else if (tick) begin
         if (bd_clr_i) begin
            bd_val_q <= 32'h0000_0000;
         end else if (rise[1] && !bd_dn_i && bd_val_q != bec_pkg::MAX8) begin
            bd_val_q <= bd_inc_w;
         end else if (rise[2] && !bd_up_i && bd_val_q != 32'h0000_0000) begin
            bd_val_q <= bd_dec_w;
         end
      end
   end

   // Stage counter: only a software clear command zeroes it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sg_val_q <= 16'h0000;
      end else if (ce_i) begin
         if (sg_clr_w) begin
            sg_val_q <= 16'h0000;
         end else if (scan_i && rise[3] && sg_val_q != bec_pkg::MAX4) begin
            sg_val_q <= sg_inc_w[15:0];
         end
      end
   end

   // Accumulating timer; divider also holds so partial steps survive
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_q    <= 24'h000000;
         tm_val_q <= 32'h0000_0000;
      end else if (ce_i) begin
         if (tm_clr_i) begin
            div_q    <= 24'h000000;
            tm_val_q <= 32'h0000_0000;
         end else if (tm_en_i) begin
            if (div_q == TICK_LAST) begin
               div_q <= 24'h000000;
               if (tm_val_q != bec_pkg::MAX8) tm_val_q <= tm_inc_w;
            end else begin
               div_q <= div_q + 24'h000001;
            end
         end
      end
   end

   // Done bits: registered compares, plain unsigned works on valid BCD
   assign up_ge  = up_val_q >= pre_up;
   assign done_d = {tm_val_q >= pre_tm, sg_val_q >= pre_sg,
                    bd_val_q >= pre_bd, up_ge};
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_q <= 4'h0;
      end else if (ce_i) begin
         done_q <= done_d;
      end
   end

   // Interrupt status: rising done sets, write one clears, set wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sts_q <= 4'h0;
         irq_q <= 1'b0;
      end else if (ce_i) begin
         sts_q <= (sts_q & ~((wr_en && idx == bec_pkg::IDX_STS && wb_sel_i[0])
                  ? wb_dat_i[3:0] : 4'h0)) | (done_d & ~done_q);
         irq_q <= |(sts_q & msk_q);
      end
   end

   // Software-written registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         psel_q <= bec_pkg::PSEL_RST;
         pup_q  <= bec_pkg::K_UP;
         pbd_q  <= bec_pkg::K_BD;
         psg_q  <= bec_pkg::K_SG;
         ptm_q  <= bec_pkg::K_TM;
         msk_q  <= 4'h0;
      end else if (ce_i && wr_en) begin
         case (idx)
            bec_pkg::IDX_PSEL:   psel_q <= wm[3:0];
            bec_pkg::IDX_PUP:    pup_q <= wm[15:0];
            bec_pkg::IDX_PBD_LO: pbd_q[15:0] <= wm[15:0];
            bec_pkg::IDX_PBD_HI: pbd_q[31:16] <= wm[15:0];
            bec_pkg::IDX_PSG:    psg_q <= wm[15:0];
            bec_pkg::IDX_PTM_LO: ptm_q[15:0] <= wm[15:0];
            bec_pkg::IDX_PTM_HI: ptm_q[31:16] <= wm[15:0];
            bec_pkg::IDX_MSK:    msk_q <= wm[3:0];
            default: ;
         endcase
      end
   end

   // Read decode; unmapped words read zero and still acknowledge
   always_comb begin
      case (idx)
         bec_pkg::IDX_PSEL:   rd_d = {28'h0, psel_q};
         bec_pkg::IDX_PUP:    rd_d = {16'h0, pup_q};
         bec_pkg::IDX_PBD_LO: rd_d = {16'h0, pbd_q[15:0]};
         bec_pkg::IDX_PBD_HI: rd_d = {16'h0, pbd_q[31:16]};
         bec_pkg::IDX_PSG:    rd_d = {16'h0, psg_q};
         bec_pkg::IDX_PTM_LO: rd_d = {16'h0, ptm_q[15:0]};
         bec_pkg::IDX_PTM_HI: rd_d = {16'h0, ptm_q[31:16]};
         bec_pkg::IDX_DONE:   rd_d = {28'h0, done_q};
         bec_pkg::IDX_STS:    rd_d = {28'h0, sts_q};
         bec_pkg::IDX_MSK:    rd_d = {28'h0, msk_q};
         bec_pkg::IDX_TM_LO:  rd_d = {16'h0, tm_val_q[15:0]};
         bec_pkg::IDX_TM_HI:  rd_d = {16'h0, tm_val_q[31:16]};
         bec_pkg::IDX_CV_UP:  rd_d = {16'h0, up_val_q};
         bec_pkg::IDX_CV_BDL: rd_d = {16'h0, bd_val_q[15:0]};
         bec_pkg::IDX_CV_BDH: rd_d = {16'h0, bd_val_q[31:16]};
         bec_pkg::IDX_CV_SG:  rd_d = {16'h0, sg_val_q};
         default:             rd_d = 32'h0000_0000;
      endcase
   end

   // Single-wait-state slave: ack one cycle after request, then drops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else if (ce_i) begin
         ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
         if (wb_cyc_i && wb_stb_i && !ack_q) dat_q <= rd_d;
      end
   end

   assign wb_dat_o  = dat_q;
   assign wb_ack_o  = ack_q;
   assign irq_o     = irq_q;
   assign up_done_o = done_q[bec_pkg::DONE_UP];
   assign bd_done_o = done_q[bec_pkg::DONE_BD];
   assign sg_done_o = done_q[bec_pkg::DONE_SG];
   assign tm_done_o = done_q[bec_pkg::DONE_TM];

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_sg_clear;
      ce_i && sg_clr_w;
   endsequence
   sequence s_sg_settle;
      ce_i && pre_sg != 16'h0000;
   endsequence

   chk_up_clear_zero: assert property (
      tick && up_clr_i |=> up_val_q == 16'h0000)
      else $error("up counter not zero under clear");
   chk_up_edge_inc: assert property (
      tick && !up_clr_i && rise[0] && up_val_q != bec_pkg::MAX4
      |=> up_val_q == $past(up_inc_w[15:0]))
      else $error("up counter missed a rising count");
   chk_up_no_edge: assert property (
      !(tick && (up_clr_i || rise[0])) |=> $stable(up_val_q))
      else $error("up counter moved without an edge");
   chk_up_sat_hold: assert property (
      up_val_q == bec_pkg::MAX4 && !(tick && up_clr_i)
      |=> up_val_q == bec_pkg::MAX4)
      else $error("up counter wrapped past maximum");
   chk_up_done_cmp: assert property (
      ce_i |=> up_done_o == $past(up_ge))
      else $error("up done does not match compare");
   chk_bd_range_ok: assert property (
      bd_val_q <= bec_pkg::MAX8 && bec_pkg::bcd_ok(bd_val_q))
      else $error("up/down value out of range");
   chk_bd_both_hold: assert property (
      tick && !bd_clr_i && bd_up_i && bd_dn_i |=> $stable(bd_val_q))
      else $error("up/down counted with both inputs on");
   chk_sg_hold_val: assert property (
      !sg_clr_w && !(tick && rise[3]) |=> $stable(sg_val_q))
      else $error("stage value changed without cause");
   chk_sg_clear_done: assert property (
      s_sg_clear ##1 s_sg_settle |=> !sg_done_o && sg_val_q <= 16'h0001)
      else $error("stage clear did not drop done");
   chk_tm_hold_off: assert property (
      !tm_en_i && !tm_clr_i |=> $stable(tm_val_q))
      else $error("timer lost or gained time while off");
   // Clears and digit range; a bad nibble would break every compare
   chk_tm_clear_zero: assert property (
      ce_i && tm_clr_i |=> tm_val_q == 32'h0000_0000)
      else $error("timer not zero after clear");
   chk_bd_clear_zero: assert property (
      tick && bd_clr_i |=> bd_val_q == 32'h0000_0000)
      else $error("up/down counter not zero after clear");
   chk_digits_valid: assert property (
      bec_pkg::bcd_ok({16'h0000, up_val_q}) && bec_pkg::bcd_ok({16'h0000, sg_val_q}))
      else $error("four-digit value holds a non-decimal nibble");
endmodule : bec_counters
`default_nettype wire

// ---- bec_ladder.sv ----
// Ladder-side model: scan strobe and count, clear and enable levels
`timescale 1ns/1ps
`default_nettype none
module bec_ladder #(
   parameter int unsigned SCAN_DIV = 2
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [7:0] lv_i,
   output logic            scan_o,
   output logic [7:0]      lv_o
);
   logic [7:0] ph_q;

   // Scan phase; one evaluation clock every SCAN_DIV clocks
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ph_q <= 8'h00;
      end else if (ph_q == 8'(SCAN_DIV - 1)) begin
         ph_q <= 8'h00;
      end else begin
         ph_q <= ph_q + 8'h01;
      end
   end

   assign scan_o = (ph_q == 8'h00);

   // Levels move only at a scan edge, so each one lasts a whole scan
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lv_o <= 8'h00;
      end else if (scan_o) begin
         lv_o <= lv_i;
      end
   end
endmodule : bec_ladder
`default_nettype wire

// ---- bec_counters_bench.sv ----
// Self-checking bench for the BCD event counters
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
   $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module bec_counters_bench;
   logic              clk_i        = 1'b0;
   logic              rst_i        = 1'b1;
   logic              cyc          = 1'b0;
   logic              stb          = 1'b0;
   logic              we           = 1'b0;
   logic [13:0]       adr          = 14'h0000;
   logic [31:0]       wdat         = 32'h0;
   logic [3:0]        sel          = 4'hF;
   logic [7:0]        lv           = 8'h00;
   logic [31:0]       rv;
   int                num_errors   = 0;
   int                total_checks = 0;
   wire  logic [31:0] rdat;
   wire  logic        ack;
   wire  logic        scan;
   wire  logic        irq;
   wire  logic [7:0]  pin;
   wire  logic [3:0]  done;

   // Clock at 100 MHz
   always #5 clk_i = ~clk_i;

   bec_ladder #(.SCAN_DIV(2)) ladder (.clk_i(clk_i), .rst_i(rst_i), .lv_i(lv),
      .scan_o(scan), .lv_o(pin));

   // Short timer step keeps the run brief
   bec_counters #(.TICK_CYC(10)) dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .scan_i(scan), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .up_cnt_i(pin[0]), .up_clr_i(pin[1]), .bd_up_i(pin[2]), .bd_dn_i(pin[3]),
      .bd_clr_i(pin[4]), .sg_cnt_i(pin[5]), .tm_en_i(pin[6]), .tm_clr_i(pin[7]),
      .up_done_o(done[0]), .bd_done_o(done[1]), .sg_done_o(done[2]),
      .tm_done_o(done[3]), .irq_o(irq));

   // Verdict and end of run
   task automatic test_done();
      if (num_errors == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : test_done

   // One classic cycle; request held until ack is seen at an edge
   task automatic xfer(input logic w, input logic [11:0] idx, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      wdat <= d;
      // Only the watchdog ends a wait for ack
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      rv = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
   endtask : xfer

   task automatic wr(input logic [11:0] idx, input logic [31:0] d);
      xfer(1'b1, idx, d);
   endtask : wr

   task automatic rd(input logic [11:0] idx, input logic [31:0] exp);
      xfer(1'b0, idx, 32'h0);
      `CHK(rv, exp)
   endtask : rd

   // Each level one scan high then one scan low
   task automatic pulse(input int b, input int n);
      repeat (n) begin
         lv[b] <= 1'b1;
         repeat (2) @(posedge clk_i);
         lv[b] <= 1'b0;
         repeat (2) @(posedge clk_i);
      end
   endtask : pulse

   // Lets model, counter, done and irq stages all land
   task automatic settle();
      repeat (8) @(posedge clk_i);
   endtask : settle

   // Watchdog, well beyond the expected run of about 41k cycles
   initial begin
      repeat (60000) @(posedge clk_i);
      num_errors++;
      test_done();
   end

   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(bec_pkg::IDX_CV_UP, 32'h0);
      rd(bec_pkg::IDX_PSEL, 32'h0);
      rd(12'h3FF, 32'h0);
      // Byte enables: only the low byte of the store preset changes
      sel <= 4'h1;
      wr(bec_pkg::IDX_PUP, 32'h0000_1234);
      sel <= 4'hF;
      rd(bec_pkg::IDX_PUP, 32'h0000_0034);
      // Up counter: steady high level counts once only
      pulse(0, 2);
      settle();
      rd(bec_pkg::IDX_CV_UP, 32'h2);
      `CHK(done[0], 1'b0)
      lv[0] <= 1'b1;
      repeat (20) @(posedge clk_i);
      lv[0] <= 1'b0;
      settle();
      rd(bec_pkg::IDX_CV_UP, 32'h3);
      `CHK(done[0], 1'b1)
      // Sticky status, mask and write-one-to-clear
      rd(bec_pkg::IDX_STS, 32'h1);
      `CHK(irq, 1'b0)
      wr(bec_pkg::IDX_MSK, 32'h1);
      settle();
      `CHK(irq, 1'b1)
      wr(bec_pkg::IDX_STS, 32'h1);
      settle();
      `CHK(irq, 1'b0)
      // Clear held on dominates a count
      lv[1] <= 1'b1;
      pulse(0, 1);
      settle();
      rd(bec_pkg::IDX_CV_UP, 32'h0);
      `CHK(done[0], 1'b0)
      lv[1] <= 1'b0;
      // Store preset of ten, decimal carry at the boundary
      wr(bec_pkg::IDX_PUP, 32'h10);
      wr(bec_pkg::IDX_PSEL, 32'h1);
      pulse(0, 9);
      settle();
      rd(bec_pkg::IDX_CV_UP, 32'h9);
      `CHK(done[0], 1'b0)
      pulse(0, 1);
      settle();
      rd(bec_pkg::IDX_CV_UP, 32'h10);
      `CHK(done[0], 1'b1)
      // Stage counter runs past the top and holds there
      pulse(5, 3);
      settle();
      `CHK(done[2], 1'b1)
      pulse(5, 9998);
      settle();
      rd(bec_pkg::IDX_CV_SG, 32'h9999);
      `CHK(done[2], 1'b1)
      wr(bec_pkg::IDX_CTRL, 32'h1);
      settle();
      rd(bec_pkg::IDX_CV_SG, 32'h0);
      `CHK(done[2], 1'b0)
      // Up/down: ten up, rise of up, refused down, two down with borrow
      pulse(2, 10);
      settle();
      rd(bec_pkg::IDX_CV_BDL, 32'h10);
      rd(bec_pkg::IDX_CV_BDH, 32'h0);
      `CHK(done[1], 1'b1)
      lv[2] <= 1'b1;
      settle();
      pulse(3, 1);
      lv[2] <= 1'b0;
      settle();
      pulse(3, 2);
      settle();
      rd(bec_pkg::IDX_CV_BDL, 32'h9);
      pulse(4, 1);
      pulse(3, 1);
      settle();
      rd(bec_pkg::IDX_CV_BDL, 32'h0);
      `CHK(done[1], 1'b0)
      // Timer: 200 cycles, pause, 150 more crosses the 3.0 s preset
      lv[6] <= 1'b1;
      repeat (200) @(posedge clk_i);
      lv[6] <= 1'b0;
      settle();
      `CHK(done[3], 1'b0)
      repeat (400) @(posedge clk_i);
      lv[6] <= 1'b1;
      repeat (150) @(posedge clk_i);
      lv[6] <= 1'b0;
      settle();
      `CHK(done[3], 1'b1)
      rd(bec_pkg::IDX_DONE, 32'h9);
      pulse(7, 1);
      settle();
      `CHK(done[3], 1'b0)
      rd(bec_pkg::IDX_TM_LO, 32'h0);
      test_done();
   end
endmodule : bec_counters_bench
`default_nettype wire
